// ---- hdl/codec_power_calibration_sequencer.sv ----
// Power-down, initialization, calibration and clock-change sequencer of the codec.
// Assumes a same-clock bus master on the register port; the pin and oscillator inputs are asynchronous.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module codec_power_calibration_sequencer
  import codec_seq_pkg::*;
#(
  parameter int SAMPLE_DIV_BASE = 256,
  parameter int RESYNC_EDGES = 16,
  parameter int OSC_START_EDGES = 64
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic power_down_pin,
  input wire logic osc_one_in,
  input wire logic osc_two_in,
  input wire logic dma_playback_busy,
  input wire logic dma_capture_busy,
  output logic ext_buffer_enable_n,
  output logic ext_buffer_direction,
  output logic dac_mute,
  output logic mixer_mute,
  output stage_t cal_stage,
  output logic playback_run_active,
  output logic capture_run_active,
  output logic serial_port_on,
  output logic osc_one_enable,
  output logic osc_two_enable
);

  // ==========================================================================
  // Parameter checks
  // ==========================================================================
  if (SAMPLE_DIV_BASE < 2 || SAMPLE_DIV_BASE > 8191) begin : g_bad_div
    $error("SAMPLE_DIV_BASE out of range");
  end
  if (RESYNC_EDGES < 1 || RESYNC_EDGES > 255 || OSC_START_EDGES < 1 || OSC_START_EDGES > 255) begin : g_bad_wait
    $error("Edge wait counts must fit the 8-bit counter");
  end

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    stage_t stage;
    logic init;
    logic cal_after;
    logic osc_pending;
    logic last_none;
    logic [1:0] cal_sel_run;
    logic [7:0] cnt;
    logic [15:0] div_cnt;
    logic [2:0] pd_sync;
    logic [2:0] osc1_sync;
    logic [2:0] osc2_sync;
    logic [4:0] index;
    logic gate;
    logic [7:0] rate;
    logic [7:0] iface;
    logic [7:0] alt_one;
    logic [7:0] alt_two;
    logic [7:0] capture;
    logic play_active;
    logic cap_active;
    logic [7:0] rdata;
    logic buf_en_n;
    logic buf_dir;
    logic dac_mute;
    logic mixer_mute;
    logic osc1_en;
    logic osc2_en;
  } state_t;

  // Power-on starts straight in the full calibration of initialization
  localparam state_t RESET_Q = '{stage: ST_CAL_MIXER, init: 1'b1, cal_sel_run: CAL_FULL,
                                 pd_sync: 3'b111, index: RST_INDEX, rate: RST_RATE, iface: RST_IFACE,
                                 alt_one: RST_ALT_ONE, alt_two: RST_ALT_TWO, capture: RST_CAPTURE,
                                 buf_en_n: 1'b1, buf_dir: 1'b1, dac_mute: 1'b1, mixer_mute: 1'b1,
                                 osc1_en: 1'b1, default: '0};

  state_t q;
  state_t d;
  logic tick;
  logic osc_edge;
  logic busy;
  logic [7:0] read_byte;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic state_t load_defaults(input state_t s);
    state_t r;
    r = s;
    r.index = RST_INDEX;
    r.gate = 1'b0;
    r.rate = RST_RATE;
    r.iface = RST_IFACE;
    r.alt_one = RST_ALT_ONE;
    r.alt_two = RST_ALT_TWO;
    r.capture = RST_CAPTURE;
    r.osc_pending = 1'b0;
    r.last_none = 1'b0;
    return r;
  endfunction : load_defaults

  function automatic logic [15:0] divisor_of(input logic [2:0] div_sel);
    return 16'(SAMPLE_DIV_BASE * (int'(div_sel) + 1));
  endfunction : divisor_of

  function automatic stage_t start_stage(input logic [1:0] sel, input logic last_none);
    unique case (sel)
      CAL_FULL: return ST_CAL_MIXER;
      CAL_CONVERTER: return ST_CAL_ADC;
      CAL_DAC_ONLY: return ST_CAL_FILTER;
      CAL_NONE: return last_none ? ST_IDLE : ST_CAL_QUIET;
    endcase
  endfunction : start_stage

  function automatic logic [7:0] phase_len(input stage_t s);
    unique case (s)
      ST_CAL_MIXER: return MIXER_SAMPLES;
      ST_CAL_ADC: return ADC_SAMPLES;
      ST_CAL_DAC: return DAC_SAMPLES;
      ST_CAL_FILTER: return FILTER_SAMPLES;
      default: return NONE_FIRST_SAMPLES;
    endcase
  endfunction : phase_len

  function automatic stage_t next_stage(input stage_t s);
    unique case (s)
      ST_CAL_MIXER: return ST_CAL_ADC;
      ST_CAL_ADC: return ST_CAL_DAC;
      default: return ST_IDLE;
    endcase
  endfunction : next_stage

  function automatic logic is_cal(input stage_t s);
    return s inside {ST_CAL_MIXER, ST_CAL_ADC, ST_CAL_DAC, ST_CAL_FILTER, ST_CAL_QUIET};
  endfunction : is_cal

  function automatic logic data_write(input logic [4:0] idx, input logic [4:0] target);
    return wr && !busy && addr == ADDR_DATA && idx == target;
  endfunction : data_write

  // ==========================================================================
  // Read mux
  // ==========================================================================
  always_comb begin
    read_byte = 8'h00;
    if (addr == ADDR_INDEX) begin
      read_byte = {1'b0, q.gate, 1'b0, q.index};
    end else if (addr == ADDR_DATA) begin
      case (q.index)
        IDX_RATE_PLAY: read_byte = q.rate;
        IDX_IFACE: read_byte = q.iface;
        IDX_STATUS: read_byte[CAL_BUSY_BIT] = is_cal(q.stage);
        IDX_ALT_ONE: read_byte = q.alt_one;
        IDX_ALT_TWO: read_byte = q.alt_two;
        IDX_CAPTURE: read_byte = {q.capture[7:4], 4'h0};
        default: read_byte = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    d = q;
    tick = 1'b0;
    d.pd_sync = {q.pd_sync[1:0], power_down_pin};
    d.osc1_sync = {q.osc1_sync[1:0], osc_one_in};
    d.osc2_sync = {q.osc2_sync[1:0], osc_two_in};
    // Sample clock derives from edges of the selected oscillator
    osc_edge = q.rate[CLK_SRC_BIT] ? (q.osc2_sync[1] & ~q.osc2_sync[2]) : (q.osc1_sync[1] & ~q.osc1_sync[2]);
    if (osc_edge) begin
      // >= guards against a divisor that shrank below the running count
      if (q.div_cnt + 16'h0001 >= divisor_of(q.rate[CLK_DIV_LSB +: 3])) begin
        d.div_cnt = 16'h0000;
        tick = 1'b1;
      end else begin
        d.div_cnt = q.div_cnt + 16'h0001;
      end
    end
    busy = q.stage == ST_POWER_DOWN || q.init || q.stage == ST_RESYNC;

    // Sequencer progression
    unique case (q.stage)
      ST_POWER_DOWN, ST_IDLE: begin
      end
      ST_RESYNC: begin
        if (osc_edge) begin
          if (q.cnt + 8'h01 >= (q.cal_after ? 8'(OSC_START_EDGES) : 8'(RESYNC_EDGES))) begin
            d.cnt = 8'h00;
            d.stage = q.cal_after ? start_stage(q.cal_sel_run, q.last_none) : ST_IDLE;
            d.last_none = q.cal_after ? (q.cal_sel_run == CAL_NONE) : q.last_none;
            d.cal_after = 1'b0;
          end else begin
            d.cnt = q.cnt + 8'h01;
          end
        end
      end
      ST_CAL_MIXER, ST_CAL_ADC, ST_CAL_DAC, ST_CAL_FILTER, ST_CAL_QUIET: begin
        if (tick) begin
          if (q.cnt + 8'h01 == phase_len(q.stage)) begin
            d.cnt = 8'h00;
            d.stage = next_stage(q.stage);
            if (next_stage(q.stage) == ST_IDLE && q.init) begin
              d = load_defaults(d);
              d.init = 1'b0;
            end
          end else begin
            d.cnt = q.cnt + 8'h01;
          end
        end
      end
    endcase

    // Host writes, all dropped while busy
    if (wr && !busy && addr == ADDR_INDEX) begin
      d.index = wdata[4:0];
      d.gate = wdata[GATE_BIT];
      if (q.gate && !wdata[GATE_BIT]) begin
        d.cal_sel_run = q.iface[CAL_SEL_LSB +: 2];
        d.osc_pending = 1'b0;
        d.cnt = 8'h00;
        if (q.osc_pending && !q.alt_two[KEEP_OSC_BIT]) begin
          d.stage = ST_RESYNC;
          d.cal_after = 1'b1;
        end else begin
          d.stage = start_stage(q.iface[CAL_SEL_LSB +: 2], q.last_none);
          d.last_none = q.iface[CAL_SEL_LSB +: 2] == CAL_NONE;
        end
      end
    end
    if (data_write(q.index, IDX_RATE_PLAY)) begin
      if (q.gate) begin
        d.rate[3:0] = wdata[3:0];
        if (wdata[3:0] != q.rate[3:0] && !q.alt_two[KEEP_OSC_BIT]) begin
          d.stage = ST_RESYNC;
          d.cnt = 8'h00;
          d.cal_after = 1'b0;
          d.osc_pending = 1'b1;
        end
      end
      if (q.gate || q.alt_one[PLAY_UNLOCK_BIT]) begin
        d.rate[7:4] = wdata[7:4];
      end
    end
    if (data_write(q.index, IDX_IFACE)) begin
      if (q.gate) begin
        d.iface = wdata;
      end else begin
        d.iface[PLAY_RUN_BIT] = wdata[PLAY_RUN_BIT];
        d.iface[CAP_RUN_BIT] = wdata[CAP_RUN_BIT];
      end
    end
    if (data_write(q.index, IDX_ALT_ONE)) begin
      d.alt_one[PLAY_UNLOCK_BIT] = wdata[PLAY_UNLOCK_BIT];
      d.alt_one[CAP_UNLOCK_BIT] = wdata[CAP_UNLOCK_BIT];
      if (q.gate) begin
        d.alt_one[SER_ON_BIT] = wdata[SER_ON_BIT];
        d.alt_one[SER_LO_BIT] = wdata[SER_LO_BIT];
        d.alt_one[SER_HI_BIT] = wdata[SER_HI_BIT];
      end
    end
    if (data_write(q.index, IDX_ALT_TWO)) begin
      d.alt_two[KEEP_OSC_BIT] = wdata[KEEP_OSC_BIT];
    end
    if (data_write(q.index, IDX_CAPTURE) && (q.gate || q.alt_one[CAP_UNLOCK_BIT])) begin
      d.capture[7:4] = wdata[7:4];
    end

    // Power-down pin overrides everything else
    if (!q.pd_sync[1]) begin
      d = load_defaults(d);
      d.stage = ST_POWER_DOWN;
      d.init = 1'b0;
      d.cal_after = 1'b0;
      d.cnt = 8'h00;
    end else if (q.stage == ST_POWER_DOWN && !q.pd_sync[2]) begin
      d = load_defaults(d);
      d.stage = ST_CAL_MIXER;
      d.init = 1'b1;
      d.cal_sel_run = CAL_FULL;
      d.cnt = 8'h00;
    end

    // Run bits only take effect between DMA transfers
    if (!dma_playback_busy) begin
      d.play_active = d.iface[PLAY_RUN_BIT];
    end
    if (!dma_capture_busy) begin
      d.cap_active = d.iface[CAP_RUN_BIT];
    end

    d.rdata = rd ? (busy ? BUSY_BYTE : read_byte) : 8'h00;
    d.buf_en_n = !(rd || wr);
    d.buf_dir = !rd;
    d.dac_mute = d.stage == ST_POWER_DOWN || (is_cal(d.stage) && d.stage != ST_CAL_QUIET);
    d.mixer_mute = d.stage == ST_POWER_DOWN || (d.cal_sel_run == CAL_FULL &&
                   d.stage inside {ST_CAL_MIXER, ST_CAL_ADC, ST_CAL_DAC});
    // Unused oscillator is stopped while KEEP_OSC_BIT is clear, to keep it from coupling into the analog side
    d.osc1_en = d.stage != ST_POWER_DOWN && (d.alt_two[KEEP_OSC_BIT] || !d.rate[CLK_SRC_BIT]);
    d.osc2_en = d.stage != ST_POWER_DOWN && (d.alt_two[KEEP_OSC_BIT] || d.rate[CLK_SRC_BIT]);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      q <= RESET_Q;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign ext_buffer_enable_n = q.buf_en_n;
  assign ext_buffer_direction = q.buf_dir;
  assign dac_mute = q.dac_mute;
  assign mixer_mute = q.mixer_mute;
  assign cal_stage = q.stage;
  assign playback_run_active = q.play_active;
  assign capture_run_active = q.cap_active;
  assign serial_port_on = q.alt_one[SER_ON_BIT];
  assign osc_one_enable = q.osc1_en;
  assign osc_two_enable = q.osc2_en;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_pd_read_busy;
    @(posedge ref_clk) disable iff (!reset_n) (q.stage == ST_POWER_DOWN && rd) |=> rdata == BUSY_BYTE && mixer_mute;
  endproperty
  a_pd_read_busy: assert property (p_pd_read_busy) else $error("Power-down read not 80 hex");

  property p_pd_rise_init;
    @(posedge ref_clk) disable iff (!reset_n)
      (q.stage == ST_POWER_DOWN && q.pd_sync[1] && !q.pd_sync[2]) |=> q.stage == ST_CAL_MIXER && q.init;
  endproperty
  a_pd_rise_init: assert property (p_pd_rise_init) else $error("No initialization after power-down");

  property p_init_write_dropped;
    @(posedge ref_clk) disable iff (!reset_n)
      (q.init && wr && q.stage == ST_CAL_MIXER && q.pd_sync[1]) |=> $stable(q.iface) && $stable(q.index);
  endproperty
  a_init_write_dropped: assert property (p_init_write_dropped) else $error("Write taken during init");

  property p_init_end_defaults;
    @(posedge ref_clk) disable iff (!reset_n)
      $fell(q.init) && q.stage == ST_IDLE |-> q.iface == RST_IFACE && q.rate == RST_RATE && !q.gate;
  endproperty
  a_init_end_defaults: assert property (p_init_end_defaults) else $error("Registers not reset after init");

  property p_rate_gated;
    @(posedge ref_clk) disable iff (!reset_n)
      (data_write(q.index, IDX_RATE_PLAY) && !q.gate && q.pd_sync[1]) |=> $stable(q.rate[3:0]);
  endproperty
  a_rate_gated: assert property (p_rate_gated) else $error("Rate bits changed without gate");

  property p_format_unlock;
    @(posedge ref_clk) disable iff (!reset_n)
      (data_write(q.index, IDX_RATE_PLAY) && q.alt_one[PLAY_UNLOCK_BIT] && q.pd_sync[1])
      |=> q.rate[7:4] == $past(wdata[7:4]);
  endproperty
  a_format_unlock: assert property (p_format_unlock) else $error("Unlocked format not written");

  property p_run_anytime;
    @(posedge ref_clk) disable iff (!reset_n)
      (data_write(q.index, IDX_IFACE) && q.pd_sync[1]) |=> q.iface[PLAY_RUN_BIT] == $past(wdata[PLAY_RUN_BIT]);
  endproperty
  a_run_anytime: assert property (p_run_anytime) else $error("Run bit not written");

  property p_gate_fall_cal;
    @(posedge ref_clk) disable iff (!reset_n)
      (wr && !busy && addr == ADDR_INDEX && q.gate && !wdata[GATE_BIT] && !q.osc_pending && q.pd_sync[1] &&
       q.iface[CAL_SEL_LSB +: 2] == CAL_CONVERTER) |=> q.stage == ST_CAL_ADC && dac_mute && !mixer_mute;
  endproperty
  a_gate_fall_cal: assert property (p_gate_fall_cal) else $error("Calibration did not start");

  property p_resync_busy;
    @(posedge ref_clk) disable iff (!reset_n) (q.stage == ST_RESYNC && rd) |=> rdata == BUSY_BYTE;
  endproperty
  a_resync_busy: assert property (p_resync_busy) else $error("Resync read not 80 hex");

  property p_keep_no_busy;
    @(posedge ref_clk) disable iff (!reset_n)
      (data_write(q.index, IDX_RATE_PLAY) && q.gate && q.alt_two[KEEP_OSC_BIT] && q.stage == ST_IDLE && q.pd_sync[1])
      |=> q.stage == ST_IDLE;
  endproperty
  a_keep_no_busy: assert property (p_keep_no_busy) else $error("Busy period with both oscillators");

  property p_phase_done;
    @(posedge ref_clk) disable iff (!reset_n)
      (q.stage == ST_CAL_DAC && tick && q.cnt == DAC_SAMPLES - 8'h01 && q.pd_sync[1]) |=> q.stage == ST_IDLE;
  endproperty
  a_phase_done: assert property (p_phase_done) else $error("Calibration did not end on count");

  property p_buffer_idle;
    @(posedge ref_clk) disable iff (!reset_n) (!rd && !wr) |=> ext_buffer_enable_n && ext_buffer_direction;
  endproperty
  a_buffer_idle: assert property (p_buffer_idle) else $error("Buffer pins not idle high");

endmodule : codec_power_calibration_sequencer

// ---- common/codec_seq_pkg.sv ----
// Constants, register layout and state codes for the codec power and calibration sequencer.
// Assumes an indexed register scheme: one index register and one data window behind it.
package codec_seq_pkg;

  // ==========================================================================
  // Register addresses
  // ==========================================================================
  localparam logic [1:0] ADDR_INDEX = 2'h0;
  localparam logic [1:0] ADDR_DATA = 2'h1;
  localparam logic [4:0] IDX_RATE_PLAY = 5'h08;
  localparam logic [4:0] IDX_IFACE = 5'h09;
  localparam logic [4:0] IDX_STATUS = 5'h0B;
  localparam logic [4:0] IDX_ALT_ONE = 5'h10;
  localparam logic [4:0] IDX_ALT_TWO = 5'h11;
  localparam logic [4:0] IDX_CAPTURE = 5'h1C;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int GATE_BIT = 6;
  localparam int CLK_SRC_BIT = 0;
  localparam int CLK_DIV_LSB = 1;
  localparam int PLAY_RUN_BIT = 0;
  localparam int CAP_RUN_BIT = 1;
  localparam int CAL_SEL_LSB = 3;
  localparam int CAL_BUSY_BIT = 5;
  localparam int SER_ON_BIT = 1;
  localparam int PLAY_UNLOCK_BIT = 4;
  localparam int CAP_UNLOCK_BIT = 5;
  localparam int SER_LO_BIT = 6;
  localparam int SER_HI_BIT = 7;
  localparam int KEEP_OSC_BIT = 1;

  // ==========================================================================
  // Reset values and fixed bytes
  // ==========================================================================
  localparam logic [7:0] BUSY_BYTE = 8'h80;
  localparam logic [4:0] RST_INDEX = 5'h00;
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [7:0] RST_IFACE = 8'h08;
  localparam logic [7:0] RST_ALT_ONE = 8'h00;
  localparam logic [7:0] RST_ALT_TWO = 8'h00;
  localparam logic [7:0] RST_CAPTURE = 8'h00;

  // ==========================================================================
  // Calibration selections and phase lengths in sample periods
  // ==========================================================================
  localparam logic [1:0] CAL_NONE = 2'h0;
  localparam logic [1:0] CAL_CONVERTER = 2'h1;
  localparam logic [1:0] CAL_DAC_ONLY = 2'h2;
  localparam logic [1:0] CAL_FULL = 2'h3;
  localparam logic [7:0] MIXER_SAMPLES = 8'h20;
  localparam logic [7:0] ADC_SAMPLES = 8'h40;
  localparam logic [7:0] DAC_SAMPLES = 8'h48;
  localparam logic [7:0] FILTER_SAMPLES = 8'h28;
  localparam logic [7:0] NONE_FIRST_SAMPLES = 8'h28;

  typedef enum logic [2:0] {
    ST_POWER_DOWN = 3'b000,
    ST_IDLE = 3'b001,
    ST_CAL_MIXER = 3'b010,
    ST_CAL_ADC = 3'b011,
    ST_CAL_DAC = 3'b100,
    ST_CAL_FILTER = 3'b101,
    ST_CAL_QUIET = 3'b110,
    ST_RESYNC = 3'b111
  } stage_t;

endpackage : codec_seq_pkg

// ---- sim/host_bus_model.sv ----
// Host bus controller model: register strobes, busy polling and two oscillators.
// Assumes the sequencer takes strobes on rising ref_clk and answers one cycle later.
`timescale 1ns/1ps
module host_bus_model (
  input logic ref_clk,
  input logic [7:0] rdata,
  input logic ext_buffer_enable_n,
  input logic ext_buffer_direction,
  input logic osc_one_enable,
  input logic osc_two_enable,
  output logic [1:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  output logic osc_one_in,
  output logic osc_two_in
);
  initial begin
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    osc_one_in = 1'b0;
    osc_two_in = 1'b0;
    #1.3;
    forever #4 osc_two_in = (osc_two_enable === 1'b1) & ~osc_two_in;
  end
  // A disabled oscillator stands still
  always #4 osc_one_in = (osc_one_enable === 1'b1) & ~osc_one_in;
  // ==========================================
  // Bus cycles
  task automatic write_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask : write_reg
  task automatic read_reg(input logic [1:0] a, output logic [9:0] got);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    got = {ext_buffer_enable_n, ext_buffer_direction, rdata};
  endtask : read_reg
  // Reads until the masked bits clear; bounded so a hang ends
  task automatic poll_clear(input logic [1:0] a, input logic [7:0] mask, output int n);
    logic [9:0] got;
    n = 0;
    got = 10'h0FF;
    while ((got[7:0] & mask) != 8'h00 && n < 4000) begin
      read_reg(a, got);
      n++;
    end
  endtask : poll_clear
endmodule : host_bus_model

// ---- sim/testbench.sv ----
// Self-checking bench: init, gating, calibration, clock change, power-down.
// Assumes oscillators of 8 ns period, so one sample tick is 4 ref_clk cycles.
`timescale 1ns/1ps
module testbench
  import codec_seq_pkg::*;
;
  localparam int TICK = 4;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic power_down_pin = 1'b1;
  logic dma_playback_busy = 1'b0;
  logic dma_capture_busy = 1'b0;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, v;
  logic wr, rd, osc_one_in, osc_two_in, ext_buffer_enable_n, ext_buffer_direction, dac_mute, mixer_mute;
  logic playback_run_active, capture_run_active, serial_port_on, osc_one_enable, osc_two_enable, gate;
  stage_t cal_stage;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  always #2 ref_clk = ~ref_clk;
  codec_power_calibration_sequencer #(.SAMPLE_DIV_BASE(2), .RESYNC_EDGES(4), .OSC_START_EDGES(2))
    u_codec_power_calibration_sequencer (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .power_down_pin(power_down_pin), .osc_one_in(osc_one_in),
    .osc_two_in(osc_two_in), .dma_playback_busy(dma_playback_busy), .dma_capture_busy(dma_capture_busy),
    .ext_buffer_enable_n(ext_buffer_enable_n), .ext_buffer_direction(ext_buffer_direction),
    .dac_mute(dac_mute), .mixer_mute(mixer_mute), .cal_stage(cal_stage), .playback_run_active(playback_run_active),
    .capture_run_active(capture_run_active), .serial_port_on(serial_port_on),
    .osc_one_enable(osc_one_enable), .osc_two_enable(osc_two_enable));
  host_bus_model u_host_bus_model (.ref_clk(ref_clk), .rdata(rdata), .ext_buffer_enable_n(ext_buffer_enable_n),
    .ext_buffer_direction(ext_buffer_direction), .osc_one_enable(osc_one_enable),
    .osc_two_enable(osc_two_enable), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .osc_one_in(osc_one_in), .osc_two_in(osc_two_in));
  // ==========================================
  // Checks and access helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic near(input int got, input int exp);
    check_count++;
    if (got > exp + 20 || got + 20 < exp) begin
      bad_count++;
      $display("Error at %0t: took %0d cycles, expected %0d", $time, got, exp);
    end
  endtask : near
  task automatic settle(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic wrr(input logic [1:0] a, input logic [7:0] d);
    u_host_bus_model.write_reg(a, d);
  endtask : wrr
  task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
    logic [9:0] got;
    u_host_bus_model.read_reg(a, got);
    check(got[7:0], exp);
    check({6'h0, got[9:8]}, 8'h00);
  endtask : rdc
  task automatic wix(input logic [4:0] i, input logic [7:0] d);
    wrr(ADDR_INDEX, {1'b0, gate, 1'b0, i});
    wrr(ADDR_DATA, d);
  endtask : wix
  task automatic rix(input logic [4:0] i, input logic [7:0] exp);
    wrr(ADDR_INDEX, {1'b0, gate, 1'b0, i});
    rdc(ADDR_DATA, exp);
  endtask : rix
  task automatic chk_reset();
    rix(IDX_RATE_PLAY, RST_RATE);
    rix(IDX_IFACE, RST_IFACE);
    rix(IDX_STATUS, 8'h00);
    rix(IDX_ALT_ONE, RST_ALT_ONE);
    rix(IDX_ALT_TWO, RST_ALT_TWO);
    rix(IDX_CAPTURE, RST_CAPTURE);
  endtask : chk_reset
  function automatic int cal_len(input logic [1:0] sel, input bit first);
    case (sel)
      2'h0: return first ? 40 : 0;
      2'h1: return 136;
      2'h2: return 40;
      default: return 168;
    endcase
  endfunction : cal_len
  function automatic stage_t first_stage(input logic [1:0] sel, input bit first);
    case (sel)
      2'h3: return ST_CAL_MIXER;
      2'h1: return ST_CAL_ADC;
      2'h2: return ST_CAL_FILTER;
      default: return first ? ST_CAL_QUIET : ST_IDLE;
    endcase
  endfunction : first_stage
  task automatic run_cal(input logic [1:0] sel, input bit first);
    gate = 1'b1;
    wix(IDX_IFACE, {3'h0, sel, 3'h0});
    gate = 1'b0;
    wrr(ADDR_INDEX, {3'h0, IDX_STATUS});
    settle(3);
    check({6'h0, dac_mute, mixer_mute}, {6'h0, sel != 2'h0, sel == 2'h3});
    check({5'h0, cal_stage}, {5'h0, first_stage(sel, first)});
    u_host_bus_model.poll_clear(ADDR_DATA, 8'hA0, n);
    near(2 * n + 3, cal_len(sel, first) * TICK);
  endtask : run_cal
  task automatic final_report();
    $display("Checks %0d, errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      final_report();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(24625));
    gate = 1'b0;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1 check({6'h0, ext_buffer_enable_n, ext_buffer_direction}, 8'h03);
    wix(IDX_IFACE, 8'hF3);
    rdc(ADDR_DATA, BUSY_BYTE);
    u_host_bus_model.poll_clear(ADDR_INDEX, 8'h80, n);
    near(2 * n + 6, 168 * TICK);
    chk_reset();
    wrr(2'h3, 8'hFF);
    rdc(2'h3, 8'h00);
    v = 8'($urandom);
    wix(IDX_IFACE, v);
    rix(IDX_IFACE, {RST_IFACE[7:2], v[1:0]});
    wix(IDX_RATE_PLAY, v);
    rix(IDX_RATE_PLAY, RST_RATE);
    wix(IDX_ALT_ONE, v | 8'h30);
    rix(IDX_ALT_ONE, 8'h30);
    v = 8'($urandom);
    wix(IDX_RATE_PLAY, v & 8'hF0);
    rix(IDX_RATE_PLAY, v & 8'hF0);
    wix(IDX_CAPTURE, v);
    wix(IDX_ALT_ONE, 8'h00);
    wix(IDX_CAPTURE, 8'h0F);
    rix(IDX_CAPTURE, v & 8'hF0);
    wix(IDX_IFACE, 8'h00);
    dma_playback_busy <= 1'b1;
    wix(IDX_IFACE, 8'h01);
    settle(3);
    check({6'h0, playback_run_active, capture_run_active}, 8'h00);
    dma_playback_busy <= 1'b0;
    settle(3);
    check({6'h0, playback_run_active, capture_run_active}, 8'h02);
    gate = 1'b1;
    wix(IDX_ALT_ONE, 8'hC2);
    rix(IDX_ALT_ONE, 8'hC2);
    check({7'h0, serial_port_on}, 8'h01);
    run_cal(2'h3, 1'b1);
    run_cal(2'h1, 1'b1);
    run_cal(2'h2, 1'b1);
    run_cal(2'h0, 1'b1);
    run_cal(2'h0, 1'b0);
    gate = 1'b1;
    wix(IDX_ALT_TWO, 8'h00);
    wix(IDX_RATE_PLAY, 8'h01);
    rdc(ADDR_INDEX, BUSY_BYTE);
    u_host_bus_model.poll_clear(ADDR_INDEX, 8'h80, n);
    check({6'h0, osc_one_enable, osc_two_enable}, 8'h01);
    gate = 1'b0;
    wrr(ADDR_INDEX, {3'h0, IDX_RATE_PLAY});
    rdc(ADDR_INDEX, BUSY_BYTE);
    u_host_bus_model.poll_clear(ADDR_INDEX, 8'h80, n);
    gate = 1'b1;
    wix(IDX_ALT_TWO, 8'h02);
    wix(IDX_RATE_PLAY, 8'h00);
    rdc(ADDR_INDEX, {3'h2, IDX_RATE_PLAY});
    check({6'h0, osc_one_enable, osc_two_enable}, 8'h03);
    power_down_pin <= 1'b0;
    settle(5);
    check({6'h0, dac_mute, mixer_mute}, 8'h03);
    check({5'h0, cal_stage}, {5'h0, ST_POWER_DOWN});
    rdc(ADDR_INDEX, BUSY_BYTE);
    gate = 1'b0;
    power_down_pin <= 1'b1;
    u_host_bus_model.poll_clear(ADDR_INDEX, 8'h80, n);
    near(2 * n, 168 * TICK);
    chk_reset();
    final_report();
  end
endmodule : testbench
